// *** ocd_pkg.sv ***
package ocd_pkg;

  // Register bus widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 9;

  // Register byte offsets
  localparam logic [8:0] ADDR_DIV1_CYCLES      = 9'h196;
  localparam logic [8:0] ADDR_DIV1_MISC        = 9'h197;
  localparam logic [8:0] ADDR_DIV1_ROUTE       = 9'h198;
  localparam logic [8:0] ADDR_CHAN_B_S1_CYCLES = 9'h199;
  localparam logic [8:0] ADDR_CHAN_B_PHASE     = 9'h19a;
  localparam logic [8:0] ADDR_CHAN_B_S2_CYCLES = 9'h19b;
  localparam logic [8:0] ADDR_CHAN_B_CTRL      = 9'h19c;
  localparam logic [8:0] ADDR_CHAN_B_DUTY      = 9'h19d;
  localparam logic [8:0] ADDR_CHAN_C_S1_CYCLES = 9'h19e;

  // Index of each register in the register array
  localparam int IDX_DIV1_CYCLES      = 0;
  localparam int IDX_DIV1_MISC        = 1;
  localparam int IDX_DIV1_ROUTE       = 2;
  localparam int IDX_CHAN_B_S1_CYCLES = 3;
  localparam int IDX_CHAN_B_PHASE     = 4;
  localparam int IDX_CHAN_B_S2_CYCLES = 5;
  localparam int IDX_CHAN_B_CTRL      = 6;
  localparam int IDX_CHAN_B_DUTY      = 7;
  localparam int IDX_CHAN_C_S1_CYCLES = 8;

  // Writable bits per register, reserved bits read as zero
  localparam logic [8:0][7:0] REG_MASK = {8'hff, 8'h01, 8'h3f, 8'hff, 8'hff,
                                          8'hff, 8'h03, 8'hff, 8'hff};
  localparam logic [7:0] REG_RESET = 8'h00;

  // Single-stage divider misc control bits
  localparam int BIT_DIV1_BYPASS = 7;
  localparam int BIT_DIV1_NOSYNC = 6;
  localparam int BIT_DIV1_FORCE  = 5;
  localparam int BIT_DIV1_START  = 4;

  // Route and duty register bits
  localparam int BIT_DIRECT_ROUTE = 1;
  localparam int BIT_DUTY_DISABLE = 0;

  // Cascaded channel control bits
  localparam int BIT_B_BYPASS_S2 = 5;
  localparam int BIT_B_BYPASS_S1 = 4;
  localparam int BIT_B_NOSYNC    = 3;
  localparam int BIT_B_FORCE     = 2;
  localparam int BIT_B_START_S2  = 1;
  localparam int BIT_B_START_S1  = 0;

  // Distribution select codes
  localparam logic [1:0] DIST_CLKIN = 2'b00;
  localparam logic [1:0] DIST_NONE  = 2'b01;
  localparam logic [1:0] DIST_VCO   = 2'b10;

  // Divider stage states
  typedef enum logic {OCD_PHASE, OCD_RUN} ocd_stage_state_t;

endpackage

// *** ocd_div_stage.sv ***
`timescale 1ns/100ps
module ocd_div_stage
  import ocd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       in_level,
  input  wire logic [3:0] low_cnt,
  input  wire logic [3:0] high_cnt,
  input  wire logic [3:0] phase,
  input  wire logic       start_high,
  input  wire logic       bypass,
  input  wire logic       restart,
  output logic            out_level
);

  typedef struct packed {
    logic             prev;
    logic             out;
    ocd_stage_state_t state;
    logic [3:0]       cnt;
    logic [3:0]       ph;
  } ocd_stage_st_t;

  ocd_stage_st_t s;
  ocd_stage_st_t next_s;
  logic          rise;
  logic [3:0]    limit;

  // Input edge and current half-period length
  assign rise  = in_level & ~s.prev;
  assign limit = s.out ? high_cnt : low_cnt;

  // Bypass, restart, phase wait and low/high counting
  always_comb begin
    next_s = s;
    next_s.prev = in_level;
    if (bypass) begin
      next_s.out = in_level;
    end else if (restart) begin
      next_s.out = start_high;
      next_s.cnt = 4'h0;
      next_s.ph = phase;
      next_s.state = (phase == 4'h0) ? OCD_RUN : OCD_PHASE;
    end else if (rise) begin
      unique case (s.state)
        OCD_PHASE: begin
          next_s.ph = s.ph - 4'h1;
          if (s.ph == 4'h1) begin
            next_s.state = OCD_RUN;
          end
        end
        OCD_RUN: begin
          if (s.cnt == limit) begin
            next_s.out = ~s.out;
            next_s.cnt = 4'h0;
          end else begin
            next_s.cnt = s.cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{prev: 1'b0, out: 1'b0, state: OCD_RUN, cnt: 4'h0, ph: 4'h0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign out_level = s.out;

  property p_start_level;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && restart && !bypass) |=> (out_level == $past(start_high));
  endproperty
  a_start_level: assert property (p_start_level)
    else $error("stage did not restart at its start level");

  property p_toggle;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && !bypass && !restart && s.state == OCD_RUN && rise && s.cnt == limit)
      |=> (out_level != $past(out_level));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("stage did not toggle at end of half period");

  property p_hold;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && !bypass && !restart && (s.state == OCD_PHASE || s.cnt != limit))
      |=> (out_level == $past(out_level));
  endproperty
  a_hold: assert property (p_hold)
    else $error("stage output changed inside a half period");

  property p_bypass;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && bypass) |=> (out_level == $past(in_level));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed stage did not follow its input");

  property p_phase_load;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && restart && !bypass && phase != 4'h0)
      |=> (s.state == OCD_PHASE && s.ph == $past(phase));
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("phase offset not loaded on restart");

endmodule // ocd_div_stage

// *** ocd_duty_fix.sv ***
`timescale 1ns/100ps
module ocd_duty_fix
  import ocd_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic in_level,
  input  wire logic duty_correction_disable,
  output logic      out_level
);

  typedef struct packed {
    logic             prev;
    logic             out;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
  } ocd_duty_st_t;

  ocd_duty_st_t     s;
  ocd_duty_st_t     next_s;
  logic [CNT_W-1:0] cnt_inc;

  assign cnt_inc = s.cnt + {{(CNT_W-1){1'b0}}, 1'b1};

  // Measure the period, then hold high for half of it
  always_comb begin
    next_s = s;
    next_s.prev = in_level;
    if (duty_correction_disable) begin
      next_s.out = in_level;
    end else if (in_level && !s.prev) begin
      next_s.period = cnt_inc;
      next_s.cnt = '0;
      next_s.out = 1'b1;
    end else begin
      if (s.cnt != {CNT_W{1'b1}}) begin
        next_s.cnt = cnt_inc;
      end
      if (cnt_inc >= (s.period >> 1)) begin
        next_s.out = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign out_level = s.out;

  property p_pass;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && duty_correction_disable) |=> (out_level == $past(in_level));
  endproperty
  a_pass: assert property (p_pass)
    else $error("uncorrected path did not follow its input");

endmodule // ocd_duty_fix

// *** ocd_output_dividers.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ocd_output_dividers
  import ocd_pkg::*;
#(
  parameter int DUTY_CNT_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              vco_level,
  input  wire logic              clkin_level,
  input  wire logic [1:0]        dist_select,
  input  wire logic              sync_n,
  output logic                   pair_two_output_a,
  output logic                   pair_two_output_b,
  output logic                   chan_b_out,
  output logic                   chan_c_stage1_out
);

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] regs;
    logic [DATA_W-1:0]               rd_data;
    logic                            pair_out;
    logic                            chan_b;
  } ocd_main_st_t;

  ocd_main_st_t s;
  ocd_main_st_t next_s;

  logic [DATA_W-1:0] r_div1_cycles;
  logic [DATA_W-1:0] r_div1_misc;
  logic [DATA_W-1:0] r_div1_route;
  logic [DATA_W-1:0] r_b_s1_cycles;
  logic [DATA_W-1:0] r_b_phase;
  logic [DATA_W-1:0] r_b_s2_cycles;
  logic [DATA_W-1:0] r_b_ctrl;
  logic [DATA_W-1:0] r_b_duty;
  logic [DATA_W-1:0] r_c_s1_cycles;
  logic              addr_hit;
  logic [3:0]        reg_idx;
  logic [ADDR_W-1:0] addr_off;
  logic              src_level;
  logic              sync_req;
  logic              div1_raw;
  logic              div1_fixed;
  logic              div1_final;
  logic              b_s1_out;
  logic              b_s2_out;
  logic              b_fixed;
  logic              c_s1_out;

  // Register fields
  assign r_div1_cycles = s.regs[IDX_DIV1_CYCLES];
  assign r_div1_misc   = s.regs[IDX_DIV1_MISC];
  assign r_div1_route  = s.regs[IDX_DIV1_ROUTE];
  assign r_b_s1_cycles = s.regs[IDX_CHAN_B_S1_CYCLES];
  assign r_b_phase     = s.regs[IDX_CHAN_B_PHASE];
  assign r_b_s2_cycles = s.regs[IDX_CHAN_B_S2_CYCLES];
  assign r_b_ctrl      = s.regs[IDX_CHAN_B_CTRL];
  assign r_b_duty      = s.regs[IDX_CHAN_B_DUTY];
  assign r_c_s1_cycles = s.regs[IDX_CHAN_C_S1_CYCLES];

  // Address decode over the contiguous register block
  assign addr_off = addr - ADDR_DIV1_CYCLES;
  assign reg_idx  = addr_off[3:0];
  assign addr_hit = (addr >= ADDR_DIV1_CYCLES) && (addr <= ADDR_CHAN_C_S1_CYCLES);

  // Divider input and chip-level sync request
  assign src_level = (dist_select == DIST_VCO) ? vco_level : clkin_level;
  assign sync_req  = ~sync_n;

  // Single-stage divider feeding the second output pair
  ocd_div_stage u_div1 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .in_level   (src_level),
    .low_cnt    (r_div1_cycles[7:4]),
    .high_cnt   (r_div1_cycles[3:0]),
    .phase      (r_div1_misc[3:0]),
    .start_high (r_div1_misc[BIT_DIV1_START]),
    .bypass     (r_div1_misc[BIT_DIV1_BYPASS]),
    .restart    (sync_req & ~r_div1_misc[BIT_DIV1_NOSYNC]),
    .out_level  (div1_raw)
  );

  ocd_duty_fix #(.CNT_W(DUTY_CNT_W)) u_div1_duty (
    .ref_clk                 (ref_clk),
    .resetn                  (resetn),
    .ce                      (ce),
    .in_level                (div1_raw),
    .duty_correction_disable (r_div1_route[BIT_DUTY_DISABLE]),
    .out_level               (div1_fixed)
  );

  // Forced high on the single-stage divider needs its sync-ignore too
  assign div1_final = (r_div1_misc[BIT_DIV1_NOSYNC] & r_div1_misc[BIT_DIV1_FORCE]) | div1_fixed;

  // Cascaded channel, first stage
  ocd_div_stage u_b_s1 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .in_level   (src_level),
    .low_cnt    (r_b_s1_cycles[7:4]),
    .high_cnt   (r_b_s1_cycles[3:0]),
    .phase      (r_b_phase[3:0]),
    .start_high (r_b_ctrl[BIT_B_START_S1]),
    .bypass     (r_b_ctrl[BIT_B_BYPASS_S1]),
    .restart    (sync_req & ~r_b_ctrl[BIT_B_NOSYNC]),
    .out_level  (b_s1_out)
  );

  // Cascaded channel, second stage clocked by the first stage
  ocd_div_stage u_b_s2 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .in_level   (b_s1_out),
    .low_cnt    (r_b_s2_cycles[7:4]),
    .high_cnt   (r_b_s2_cycles[3:0]),
    .phase      (r_b_phase[7:4]),
    .start_high (r_b_ctrl[BIT_B_START_S2]),
    .bypass     (r_b_ctrl[BIT_B_BYPASS_S2]),
    .restart    (sync_req & ~r_b_ctrl[BIT_B_NOSYNC]),
    .out_level  (b_s2_out)
  );

  ocd_duty_fix #(.CNT_W(DUTY_CNT_W)) u_b_duty (
    .ref_clk                 (ref_clk),
    .resetn                  (resetn),
    .ce                      (ce),
    .in_level                (b_s2_out),
    .duty_correction_disable (r_b_duty[BIT_DUTY_DISABLE]),
    .out_level               (b_fixed)
  );

  // Next channel, first stage: timing fields only, always obeys sync
  ocd_div_stage u_c_s1 (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .ce         (ce),
    .in_level   (src_level),
    .low_cnt    (r_c_s1_cycles[7:4]),
    .high_cnt   (r_c_s1_cycles[3:0]),
    .phase      (4'h0),
    .start_high (1'b0),
    .bypass     (1'b0),
    .restart    (sync_req),
    .out_level  (c_s1_out)
  );

  // Register writes, read data and output routing
  always_comb begin
    next_s = s;
    next_s.rd_data = '0;
    if (wr_en && addr_hit) begin
      next_s.regs[reg_idx] = wr_data & REG_MASK[reg_idx];
    end
    if (rd_en && addr_hit) begin
      next_s.rd_data = s.regs[reg_idx];
    end
    next_s.pair_out = div1_final;
    if (r_div1_route[BIT_DIRECT_ROUTE]) begin
      if (dist_select == DIST_VCO) begin
        next_s.pair_out = vco_level;
      end else if (dist_select == DIST_CLKIN) begin
        next_s.pair_out = clkin_level;
      end
    end
    if (r_b_ctrl[BIT_B_NOSYNC] && r_b_ctrl[BIT_B_FORCE]) begin
      next_s.chan_b = 1'b1;
    end else begin
      next_s.chan_b = b_fixed;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{regs: {NUM_REGS{REG_RESET}}, rd_data: '0, pair_out: 1'b0, chan_b: 1'b0};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // Outputs from flip-flops
  assign rd_data           = s.rd_data;
  assign pair_two_output_a = s.pair_out;
  assign pair_two_output_b = s.pair_out;
  assign chan_b_out        = s.chan_b;
  assign chan_c_stage1_out = c_s1_out;

  property p_route_vco;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_div1_route[BIT_DIRECT_ROUTE] && dist_select == DIST_VCO)
      |=> (pair_two_output_a == $past(vco_level));
  endproperty
  a_route_vco: assert property (p_route_vco)
    else $error("pair not routed from the VCO");

  property p_route_clkin;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_div1_route[BIT_DIRECT_ROUTE] && dist_select == DIST_CLKIN)
      |=> (pair_two_output_b == $past(clkin_level));
  endproperty
  a_route_clkin: assert property (p_route_clkin)
    else $error("pair not routed from the clock input");

  property p_route_div;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && (!r_div1_route[BIT_DIRECT_ROUTE] || dist_select == DIST_NONE))
      |=> (pair_two_output_a == $past(div1_final));
  endproperty
  a_route_div: assert property (p_route_div)
    else $error("pair not driven from its divider");

  property p_force;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_b_ctrl[BIT_B_NOSYNC] && r_b_ctrl[BIT_B_FORCE]) |=> chan_b_out;
  endproperty
  a_force: assert property (p_force)
    else $error("forced level not driven");

  property p_sync_obey;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && sync_req && !r_b_ctrl[BIT_B_NOSYNC] && !r_b_ctrl[BIT_B_BYPASS_S1])
      |=> (b_s1_out == $past(r_b_ctrl[BIT_B_START_S1]));
  endproperty
  a_sync_obey: assert property (p_sync_obey)
    else $error("cascaded channel ignored an honoured sync");

  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && rd_en && !addr_hit) |=> (rd_data == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  property p_div1_force;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_div1_misc[BIT_DIV1_NOSYNC] && r_div1_misc[BIT_DIV1_FORCE]
      && !r_div1_route[BIT_DIRECT_ROUTE]) |=> pair_two_output_a;
  endproperty
  a_div1_force: assert property (p_div1_force)
    else $error("single-stage forced level not on the pair");

  property p_no_force;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && !r_b_ctrl[BIT_B_NOSYNC]) |=> (chan_b_out == $past(b_fixed));
  endproperty
  a_no_force: assert property (p_no_force)
    else $error("cascaded output overridden without sync-ignore");

  property p_s2_start;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && sync_req && !r_b_ctrl[BIT_B_NOSYNC] && !r_b_ctrl[BIT_B_BYPASS_S2])
      |=> (b_s2_out == $past(r_b_ctrl[BIT_B_START_S2]));
  endproperty
  a_s2_start: assert property (p_s2_start)
    else $error("second stage did not restart at its start level");

  property p_c_restart;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && sync_req) |=> !chan_c_stage1_out;
  endproperty
  a_c_restart: assert property (p_c_restart)
    else $error("next channel stage did not restart low");

  property p_s1_bypass;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_b_ctrl[BIT_B_BYPASS_S1]) |=> (b_s1_out == $past(src_level));
  endproperty
  a_s1_bypass: assert property (p_s1_bypass)
    else $error("bypassed first stage did not pass its input");

  property p_s2_bypass;
    @(posedge ref_clk) disable iff (!resetn)
    (ce && r_b_ctrl[BIT_B_BYPASS_S2]) |=> (b_s2_out == $past(b_s1_out));
  endproperty
  a_s2_bypass: assert property (p_s2_bypass)
    else $error("bypassed second stage did not pass its input");

endmodule // ocd_output_dividers

// *** ocd_output_dividers_tb_top.sv ***
`timescale 1ns/100ps
module ocd_output_dividers_tb_top
  import ocd_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              vco_level = 1'b0;
  logic              clkin_level = 1'b0;
  logic [1:0]        dist_select = 2'b00;
  logic              sync_n = 1'b1;
  logic              pair_two_output_a;
  logic              pair_two_output_b;
  logic              chan_b_out;
  logic              chan_c_stage1_out;
  int unsigned       cyc = 0;
  int                error_cnt = 0;
  int                compares = 0;
  logic [31:0]       seed = 32'h4475e7bb;
  logic [7:0]        shadow [NUM_REGS];

  ocd_output_dividers u_ocd_output_dividers (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .ce               (ce),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data          (rd_data),
    .vco_level        (vco_level),
    .clkin_level      (clkin_level),
    .dist_select      (dist_select),
    .sync_n           (sync_n),
    .pair_two_output_a(pair_two_output_a),
    .pair_two_output_b(pair_two_output_b),
    .chan_b_out       (chan_b_out),
    .chan_c_stage1_out(chan_c_stage1_out)
  );

  // Reference clock, 20 ns period
  always #10 ref_clk = ~ref_clk;

  // Divider sources: VCO period 2 cycles, clock input period 4 cycles
  always @(posedge ref_clk) begin
    cyc         <= cyc + 1;
    vco_level   <= ~vco_level;
    clkin_level <= cyc[1];
  end

  // Pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Register model read
  function automatic logic [7:0] model_rd(input logic [8:0] a);
    if (a < ADDR_DIV1_CYCLES || a > ADDR_CHAN_C_S1_CYCLES) return 8'h00;
    return shadow[a - ADDR_DIV1_CYCLES];
  endfunction

  // Output under observation
  function automatic logic pick(input int sel);
    case (sel)
      0: return chan_c_stage1_out;
      1: return chan_b_out;
      3: return pair_two_output_b;
      default: return pair_two_output_a;
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One-cycle write; the model keeps only what the design stores
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    if (a >= ADDR_DIV1_CYCLES && a <= ADDR_CHAN_C_S1_CYCLES && ce === 1'b1) begin
      shadow[a - ADDR_DIV1_CYCLES] = d & REG_MASK[a - ADDR_DIV1_CYCLES];
    end
  endtask

  // One-cycle read; data stands for one cycle only
  task automatic reg_rd_chk(input logic [8:0] a);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    check("rd_data", rd_data, model_rd(a));
    @(posedge ref_clk);
    #1;
    check("rd_data idle", rd_data, 8'h00);
  endtask

  // Count cycles until the output reaches a level, bounded
  task automatic run_until(input int sel, input logic v, output int n);
    n = 0;
    while (pick(sel) !== v) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 4000) begin
        check("wait bound", 16'h0, 16'h1);
        tally_and_finish();
      end
    end
  endtask

  // Skip two periods, then measure high and low widths in cycles
  task automatic meas_chk(input int sel, input int ehi, input int elo);
    int n;
    int hi;
    int lo;
    repeat (2) begin
      run_until(sel, 1'b0, n);
      run_until(sel, 1'b1, n);
    end
    run_until(sel, 1'b0, hi);
    run_until(sel, 1'b1, lo);
    check("high width", hi, ehi);
    check("low width", lo, elo);
  endtask

  // Output must stay at one level for 40 cycles
  task automatic hold_chk(input int sel, input logic v);
    int bad;
    bad = 0;
    repeat (6) @(posedge ref_clk);
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      bad += (pick(sel) !== v);
    end
    check("steady level", bad, 0);
  endtask

  // Hold sync, release on a fixed clock-input phase, time the first rise
  task automatic sync_delay(input int sel, output int n);
    @(posedge ref_clk);
    sync_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    while (cyc % 4 != 0) @(posedge ref_clk);
    sync_n <= 1'b1;
    run_until(sel, 1'b1, n);
  endtask

  // Main sequence
  initial begin
    int         d0;
    int         d1;
    int         p;
    logic [7:0] cv [3];
    logic [7:0] bctl [3] = '{8'h30, 8'h20, 8'h10};
    int         bhi [3] = '{2, 4, 8};
    int         blo [3] = '{2, 8, 4};
    logic [1:0] rds [3] = '{2'b00, 2'b10, 2'b01};
    int         rhi [3] = '{2, 1, 4};
    int         rlo [3] = '{2, 1, 12};
    logic [8:0] padr [3] = '{9'h197, 9'h19a, 9'h19a};
    logic [7:0] pctl [3] = '{8'h00, 8'h20, 8'h10};
    int         psel [3] = '{2, 1, 1};
    logic [7:0] pval [3];
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, unmapped neighbours included
    for (int a = 'h195; a <= 'h19f; a++) reg_rd_chk(a[8:0]);
    for (int a = 'h196; a <= 'h19f; a++) begin
      seed = lfsr_next(seed);
      reg_wr(a[8:0], seed[7:0]);
    end
    for (int a = 'h195; a <= 'h19f; a++) reg_rd_chk(a[8:0]);
    // Writes with clock enable low are ignored
    @(posedge ref_clk);
    ce <= 1'b0;
    reg_wr(ADDR_CHAN_C_S1_CYCLES, ~shadow[IDX_CHAN_C_S1_CYCLES]);
    ce <= 1'b1;
    reg_rd_chk(ADDR_CHAN_C_S1_CYCLES);
    // Second reset in mid-run
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    reg_rd_chk(ADDR_CHAN_B_PHASE);
    // Next channel first stage widths
    seed = lfsr_next(seed);
    cv = '{8'h00, 8'hff, seed[15:8]};
    for (int i = 0; i < 3; i++) begin
      reg_wr(ADDR_CHAN_C_S1_CYCLES, cv[i]);
      meas_chk(0, (int'(cv[i][3:0]) + 1) * 4, (int'(cv[i][7:4]) + 1) * 4);
    end
    // Cascaded channel, both stages counting, then each stage bypass setting
    reg_wr(ADDR_CHAN_B_DUTY, 8'h01);
    reg_wr(ADDR_CHAN_B_S1_CYCLES, 8'h10);
    reg_wr(ADDR_CHAN_B_S2_CYCLES, 8'h01);
    meas_chk(1, 2 * 3 * 4, 1 * 3 * 4);
    reg_wr(ADDR_CHAN_B_DUTY, 8'h00);
    meas_chk(1, 18, 18);
    reg_wr(ADDR_CHAN_B_DUTY, 8'h01);
    for (int i = 0; i < 3; i++) begin
      reg_wr(ADDR_CHAN_B_CTRL, bctl[i]);
      meas_chk(1, bhi[i], blo[i]);
    end
    // Force and sync-ignore
    reg_wr(ADDR_CHAN_B_CTRL, 8'h0c);
    hold_chk(1, 1'b1);
    reg_wr(ADDR_CHAN_B_CTRL, 8'h04);
    meas_chk(1, 24, 12);
    reg_wr(ADDR_CHAN_B_CTRL, 8'h08);
    @(posedge ref_clk);
    sync_n <= 1'b0;
    meas_chk(1, 24, 12);
    // Start levels while sync is held
    reg_wr(ADDR_DIV1_ROUTE, 8'h01);
    for (int st = 0; st < 4; st++) begin
      reg_wr(ADDR_DIV1_MISC, st[0] ? 8'h10 : 8'h00);
      reg_wr(ADDR_CHAN_B_CTRL, st[7:0]);
      hold_chk(1, st[1]);
      hold_chk(2, st[0]);
      reg_wr(ADDR_CHAN_B_CTRL, 8'h20 | st[7:0]);
      hold_chk(1, st[0]);
    end
    @(posedge ref_clk);
    sync_n <= 1'b1;
    reg_wr(ADDR_DIV1_MISC, 8'h00);
    // Second pair routing per distribution select
    reg_wr(ADDR_DIV1_CYCLES, 8'h20);
    reg_wr(ADDR_DIV1_ROUTE, 8'h03);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      dist_select <= rds[i];
      meas_chk(2, rhi[i], rlo[i]);
    end
    meas_chk(3, 4, 12);
    reg_wr(ADDR_DIV1_ROUTE, 8'h00);
    meas_chk(2, 8, 8);
    @(posedge ref_clk);
    dist_select <= 2'b00;
    // Phase offsets measured against a zero offset
    reg_wr(ADDR_DIV1_CYCLES, 8'h00);
    reg_wr(ADDR_DIV1_ROUTE, 8'h01);
    reg_wr(ADDR_CHAN_B_S1_CYCLES, 8'h00);
    reg_wr(ADDR_CHAN_B_S2_CYCLES, 8'h00);
    seed = lfsr_next(seed);
    p = 1 + int'(seed[2:0]);
    pval = '{p[7:0], p[7:0], p[7:0] << 4};
    for (int i = 0; i < 3; i++) begin
      reg_wr(ADDR_CHAN_B_CTRL, pctl[i]);
      reg_wr(padr[i], 8'h00);
      sync_delay(psel[i], d0);
      reg_wr(padr[i], pval[i]);
      sync_delay(psel[i], d1);
      check("phase delay", d1 - d0, p * 4);
      reg_wr(padr[i], 8'h00);
    end
    // Single-stage divider bypass, forced level, force without sync-ignore
    reg_wr(ADDR_DIV1_MISC, 8'h80);
    meas_chk(2, 2, 2);
    reg_wr(ADDR_DIV1_MISC, 8'h60);
    hold_chk(2, 1'b1);
    reg_wr(ADDR_DIV1_MISC, 8'h20);
    meas_chk(2, 4, 4);
    tally_and_finish();
  end

endmodule // ocd_output_dividers_tb_top
